// *** dv/tb.sv ***
// Testbench for the timing output selector.
`timescale 1ns/10ps
module tb;
  import tout_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, pin, drv;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  cfg [4];
  timing_src_t src;
  int          num_errors, checks_done, cyc, seed;

  timing_output_selector_5_to_8 uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timing_src(src),
    .timing_out(pin), .timing_drive_high(drv));
  timing_src_model gen (.aclk(aclk), .src(src));

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic exp_pin(logic [3:0] c, logic [11:0] v);
    if (c >= 4'h1 && c <= 4'h8) return v[c-1];
    if (c >= 4'ha && c <= 4'hd) return v[c-2];
    return 1'b0;
  endfunction
  task automatic wr(input logic [9:0] a, input logic [31:0] dv);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
  endtask
  task automatic rd(input logic [9:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask
  task automatic chk_pins;
    logic [3:0] e, ed;
    // Two looks, so the pins are seen to follow the moving sources.
    repeat (2) begin
      @(negedge aclk);
      for (int i = 0; i < 4; i++) begin
        e[i] = exp_pin(cfg[i][3:0], src);
        ed[i] = cfg[i][4];
      end
      chk(pin, e);
      chk(drv, ed);
    end
    @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 39;
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3f;
    {num_errors, checks_done, cyc} = 96'h0;
    repeat (2) begin
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
        cfg[i] = 5'(i + 5);
        rd({IDX_OUT5_ROUTE + 8'(i), 2'b00});
        chk(d, 32'(i + 5));
      end
      chk_pins();
      for (int i = 0; i < 4; i++) begin
        for (int c = 0; c < 16; c++) begin
          cfg[i] = {1'($random(seed)), 4'(c)};
          wr({IDX_OUT5_ROUTE + 8'(i), 2'b00}, {27'h0, cfg[i]});
          chk(r, RESP_OKAY);
          chk_pins();
          rd({IDX_OUT5_ROUTE + 8'(i), 2'b00});
          chk(d, {27'h0, cfg[i]});
        end
      end
      // A write with the low byte lane off must leave the register alone.
      wstrb <= 4'h0;
      wr({IDX_OUT5_ROUTE, 2'b00}, 32'h0000001f);
      chk(r, RESP_OKAY);
      wstrb <= 4'hf;
      rd({IDX_OUT5_ROUTE, 2'b00});
      chk(d, {27'h0, cfg[0]});
      wr(10'h12c, 32'h0000001f);
      chk(r, RESP_SLVERR);
      rd(10'h12c);
      chk(d, 32'h0);
      chk(r, RESP_SLVERR);
      chk_pins();
    end
    tally_and_finish();
  end
endmodule // tb

bind timing_output_selector_5_to_8 tout_props props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .timing_src, .timing_out, .timing_drive_high);

// *** dv/timing_src_model.sv ***
// Model of the timing generator feeding the output selectors.
`timescale 1ns/10ps
module timing_src_model
  import tout_pkg::*;
(
  // Clock.
  input  wire logic            aclk,
  // Timing sources.
  output tout_pkg::timing_src_t src
);
  logic [15:0] lfsr_r;
  wire         lfsr_fb = lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10];

  // Every source toggles freely so a wrong selection shows up quickly.
  initial lfsr_r = 16'hace1;
  always @(posedge aclk) begin
    lfsr_r <= {lfsr_r[14:0], lfsr_fb};
  end
  assign src = lfsr_r[11:0];
endmodule // timing_src_model

// *** dv/tout_props.sv ***
// Checker for bus handshakes and pin routing.
`timescale 1ns/10ps
module tout_props
  import tout_pkg::*;
(
  // Clock and reset.
  input wire logic            aclk,
  input wire logic            aresetn,
  // Bus handshake.
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic [31:0]     s_axi_rdata,
  // Pins.
  input wire tout_pkg::timing_src_t timing_src,
  input wire logic [3:0]      timing_out,
  input wire logic [3:0]      timing_drive_high
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_drive_a: assert property (
    $rose(aresetn) |-> timing_drive_high == 4'h0)
    else $error("drive not low after reset");
  rst_out5_a: assert property (
    $rose(aresetn) |-> timing_out[0] == timing_src.field_sync)
    else $error("output five not on field sync");
  rst_out6_a: assert property (
    $rose(aresetn) |-> timing_out[1] == timing_src.field_digital)
    else $error("output six not on field digital");
  rst_out7_a: assert property (
    $rose(aresetn) |-> timing_out[2] == timing_src.ten_field_ident)
    else $error("output seven not on ten field ident");
  rst_out8_a: assert property (
    $rose(aresetn) |-> timing_out[3] == timing_src.active_video_window)
    else $error("output eight not on active window");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  resp_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:5] == 27'h0)
    else $error("read answer wrong");
  drive_cause_a: assert property (
    $changed(timing_drive_high) |-> s_axi_bvalid)
    else $error("drive changed without write");
endmodule // tout_props

// *** rtl/axil_regs.sv ***
// AXI4-Lite slave holding the four output route registers.
`timescale 1ns/10ps
module axil_regs
  import tout_pkg::*;
(
  // Clock and reset.
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Write channels.
  input  wire logic [9:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // Read channels.
  input  wire logic [9:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Register contents.
  output logic [4*16-1:0]         regs_flat
);
  import tout_pkg::*;

  localparam logic [15:0] RST_VAL [4] = '{RST_OUT5, RST_OUT6, RST_OUT7,
                                          RST_OUT8};
  localparam logic [7:0]  IDX_VAL [4] = '{IDX_OUT5_ROUTE, IDX_OUT6_ROUTE,
                                          IDX_OUT7_ROUTE, IDX_OUT8_ROUTE};

  logic [15:0] regs_r [4];
  logic [9:0]  awaddr_r;
  logic        aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_held_r;

  //////////////////////////////////////////////////////////////////////////
  // Write path: address and data are latched in either order.
  wire       aw_take = awvalid & awready;
  wire       w_take  = wvalid & wready;
  wire       do_wr   = aw_held_r & w_held_r & ~bvalid;
  wire [7:0] wr_idx  = awaddr_r[9:2];
  logic [3:0] wr_hit;
  logic [3:0] rd_hit;
  wire [7:0] rd_idx  = araddr[9:2];

  assign awready = ~aw_held_r & ~bvalid;
  assign wready  = ~w_held_r & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (|wr_hit) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register storage; reserved bits 15-5 are kept at zero.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_reg
      assign wr_hit[gi] = (wr_idx == IDX_VAL[gi]);
      assign rd_hit[gi] = (rd_idx == IDX_VAL[gi]);
      assign regs_flat[gi*16 +: 16] = regs_r[gi];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          regs_r[gi] <= RST_VAL[gi];
        end else if (do_wr && wr_hit[gi] && wstrb_r[0]) begin
          regs_r[gi] <= {11'h000, wdata_r[4:0]};
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read path: one-cycle answer, unmapped addresses give SLVERR.
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= (|rd_hit) ? RESP_OKAY : RESP_SLVERR;
      rdata  <= rd_hit[0] ? {16'h0000, regs_r[0]} :
                rd_hit[1] ? {16'h0000, regs_r[1]} :
                rd_hit[2] ? {16'h0000, regs_r[2]} :
                rd_hit[3] ? {16'h0000, regs_r[3]} : 32'h0000_0000;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // axil_regs

// *** rtl/route_mux.sv ***
// One timing-output selector: picks a source and passes drive strength.
`timescale 1ns/10ps
module route_mux
  import tout_pkg::*;
(
  // Configuration and sources.
  input  wire tout_pkg::route_cfg_t  cfg,
  input  wire logic [15:0]           src_vec,
  // Pin side.
  output logic                       pin_out,
  output logic                       pin_drive_high
);

  // Combinational, so a new selection shows at once.
  assign pin_out        = src_vec[cfg.sel];
  assign pin_drive_high = cfg.drive_high;

endmodule // route_mux

// *** rtl/timing_output_selector_5_to_8.sv ***
// Top: route registers and pin selectors for timing outputs five to eight.
`timescale 1ns/10ps
module timing_output_selector_5_to_8
  import tout_pkg::*;
#(
  parameter int unsigned N_OUT = tout_pkg::NUM_OUTPUTS
)
(
  // Clock and reset.
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [9:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [9:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Timing sources from the internal generator.
  input  wire tout_pkg::timing_src_t timing_src,
  // Timing output pins five to eight, index 0 is output five.
  output logic [3:0]               timing_out,
  output logic [3:0]               timing_drive_high
);
  import tout_pkg::*;

  if (N_OUT != NUM_OUTPUTS) begin : g_bad_n
    $error("N_OUT must equal four");
  end

  logic [4*16-1:0] regs_flat;
  logic [15:0]     src_vec;

  //////////////////////////////////////////////////////////////////////////
  // Register file.
  axil_regs u_regs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (s_axi_awaddr),
    .awvalid   (s_axi_awvalid),
    .awready   (s_axi_awready),
    .wdata     (s_axi_wdata),
    .wstrb     (s_axi_wstrb),
    .wvalid    (s_axi_wvalid),
    .wready    (s_axi_wready),
    .bresp     (s_axi_bresp),
    .bvalid    (s_axi_bvalid),
    .bready    (s_axi_bready),
    .araddr    (s_axi_araddr),
    .arvalid   (s_axi_arvalid),
    .arready   (s_axi_arready),
    .rdata     (s_axi_rdata),
    .rresp     (s_axi_rresp),
    .rvalid    (s_axi_rvalid),
    .rready    (s_axi_rready),
    .regs_flat (regs_flat)
  );

  //////////////////////////////////////////////////////////////////////////
  // Source table: codes 0, 9 and above 13 drive low.
  assign src_vec[SEL_OFF]      = 1'b0;
  assign src_vec[SEL_HSYNC]    = timing_src.horz_sync;
  assign src_vec[SEL_HBLANK]   = timing_src.horz_blank;
  assign src_vec[SEL_VSYNC]    = timing_src.vert_sync;
  assign src_vec[SEL_VBLANK]   = timing_src.vert_blank;
  assign src_vec[SEL_FSYNC]    = timing_src.field_sync;
  assign src_vec[SEL_FDIGITAL] = timing_src.field_digital;
  assign src_vec[SEL_TENFIELD] = timing_src.ten_field_ident;
  assign src_vec[SEL_ACTIVE]   = timing_src.active_video_window;
  assign src_vec[9]            = 1'b0;
  assign src_vec[13:10]        = timing_src.user_defined;
  assign src_vec[15:14]        = 2'b00;

  //////////////////////////////////////////////////////////////////////////
  // One selector per output.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      route_cfg_t cfg;
      assign cfg.sel        = regs_flat[gi*16 + SEL_LSB +: SEL_W];
      assign cfg.drive_high = regs_flat[gi*16 + DRIVE_BIT];
      route_mux u_mux (
        .cfg            (cfg),
        .src_vec        (src_vec),
        .pin_out        (timing_out[gi]),
        .pin_drive_high (timing_drive_high[gi])
      );
    end
  endgenerate

endmodule // timing_output_selector_5_to_8

// *** rtl/tout_pkg.sv ***
// Package with register map, field layout and selection codes.
package tout_pkg;

  localparam int unsigned NUM_OUTPUTS = 4;
  localparam int unsigned SEL_W       = 4;
  localparam int unsigned NUM_SRC     = 16;

  // Printed register indices; byte address is four times the index.
  localparam logic [7:0] IDX_OUT5_ROUTE = 8'h47;
  localparam logic [7:0] IDX_OUT6_ROUTE = 8'h48;
  localparam logic [7:0] IDX_OUT7_ROUTE = 8'h49;
  localparam logic [7:0] IDX_OUT8_ROUTE = 8'h4a;
  localparam int unsigned ADDR_W      = 10;

  // Field layout of each route register.
  localparam int unsigned SEL_LSB     = 0;
  localparam int unsigned DRIVE_BIT   = 4;
  localparam int unsigned REG_W       = 16;

  // Selection codes.
  localparam logic [3:0] SEL_OFF      = 4'h0;
  localparam logic [3:0] SEL_HSYNC    = 4'h1;
  localparam logic [3:0] SEL_HBLANK   = 4'h2;
  localparam logic [3:0] SEL_VSYNC    = 4'h3;
  localparam logic [3:0] SEL_VBLANK   = 4'h4;
  localparam logic [3:0] SEL_FSYNC    = 4'h5;
  localparam logic [3:0] SEL_FDIGITAL = 4'h6;
  localparam logic [3:0] SEL_TENFIELD = 4'h7;
  localparam logic [3:0] SEL_ACTIVE   = 4'h8;

  // Reset values of the four route registers.
  localparam logic [15:0] RST_OUT5 = 16'h0005;
  localparam logic [15:0] RST_OUT6 = 16'h0006;
  localparam logic [15:0] RST_OUT7 = 16'h0007;
  localparam logic [15:0] RST_OUT8 = 16'h0008;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Route setting of one output.
  typedef struct packed {
    logic       drive_high;
    logic [3:0] sel;
  } route_cfg_t;

  // Timing sources offered to the selectors.
  typedef struct packed {
    logic [3:0] user_defined;
    logic       active_video_window;
    logic       ten_field_ident;
    logic       field_digital;
    logic       field_sync;
    logic       vert_blank;
    logic       vert_sync;
    logic       horz_blank;
    logic       horz_sync;
  } timing_src_t;

endpackage : tout_pkg
